//--- toc_config_regs.sv
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

// Function
// - offset limit field, bits 7:6, reset zero
// - pre-sync block length, 8 to 256 symbols
// - nonzero limit: pre field gives proportional factor
// - pre field 1xx: 1/16 after sync
// - post-sync block length field, reset 011
// - post codes 001..101 give 16..256 symbols
// - nonzero limit: post field gives integral factor
module toc_config_regs #(
   parameter int unsigned ADDR_W = toc_pkg::AXI_ADDR_W
) (
   // clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
   input  wire logic                  s_axi_awvalid_in,
   output logic                       s_axi_awready_out,
   // axi4-lite write data
   input  wire logic [31:0]           s_axi_wdata_in,
   input  wire logic [3:0]            s_axi_wstrb_in,
   input  wire logic                  s_axi_wvalid_in,
   output logic                       s_axi_wready_out,
   // axi4-lite write response
   output logic [1:0]                 s_axi_bresp_out,
   output logic                       s_axi_bvalid_out,
   input  wire logic                  s_axi_bready_in,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
   input  wire logic                  s_axi_arvalid_in,
   output logic                       s_axi_arready_out,
   // axi4-lite read data
   output logic [31:0]                s_axi_rdata_out,
   output logic [1:0]                 s_axi_rresp_out,
   output logic                       s_axi_rvalid_out,
   input  wire logic                  s_axi_rready_in,
   // demodulator events and neighbour state
   input  wire logic                  sync_event_in,
   input  wire logic                  rx_start_in,
   input  wire logic                  carrier_sense_gate_in,
   // applied timing recovery setting
   output toc_pkg::toc_setting_t      setting_out,
   output logic [1:0]                 symbol_rate_offset_limit_out
);

   if (ADDR_W < 3 || ADDR_W > toc_pkg::AXI_ADDR_W) begin : g_bad_addr_w
      $error("toc_config_regs: ADDR_W must lie between 3 and 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0]            timing_offset_correction_config_r;
   logic                  post_sync_r;
   logic                  aw_held_r;
   logic [ADDR_W-1:0]     aw_addr_r;
   logic                  w_held_r;
   logic [31:0]           w_data_r;
   logic [3:0]            w_strb_r;
   logic                  do_write;
   logic                  ar_take;
   logic [7:0]            wr_addr;
   logic [7:0]            rd_addr;
   logic [31:0]           status_word;

   assign wr_addr  = 8'(aw_addr_r);
   assign rd_addr  = 8'(s_axi_araddr_in);
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid_out;
   assign ar_take  = s_axi_arvalid_in && s_axi_arready_out;

   ////////////////////////////////////////////////////////////////////////////
   // write address and data are caught independently, in either order

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_held_r         <= 1'b0;
         aw_addr_r         <= '0;
         s_axi_awready_out <= 1'b0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr_in;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         // ready only while the slot is empty, so one write at a time
         s_axi_awready_out <= !aw_held_r && !s_axi_awready_out &&
                              !(s_axi_awvalid_in && s_axi_awready_out);
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         w_held_r         <= 1'b0;
         w_data_r         <= '0;
         w_strb_r         <= '0;
         s_axi_wready_out <= 1'b0;
      end else begin
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
         s_axi_wready_out <= !w_held_r && !s_axi_wready_out &&
                             !(s_axi_wvalid_in && s_axi_wready_out);
      end
   end

   // response follows both halves; unmapped or read-only targets get slverr
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= toc_pkg::RESP_OKAY;
      end else begin
         if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= (wr_addr == toc_pkg::ADDR_CONFIG) ?
                                toc_pkg::RESP_OKAY : toc_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration register, only byte lane 0 carries it

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         timing_offset_correction_config_r <= {toc_pkg::LIMIT_RESET,
                                               toc_pkg::PRE_RESET,
                                               toc_pkg::POST_RESET};
      end else if (do_write && wr_addr == toc_pkg::ADDR_CONFIG && w_strb_r[0]) begin
         timing_offset_correction_config_r <= w_data_r[toc_pkg::CFG_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sync state: a sync event in the same cycle as a new reception wins,
   // so a sync found right at the boundary is never dropped

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         post_sync_r <= 1'b0;
      end else if (sync_event_in) begin
         post_sync_r <= 1'b1;
      end else if (rx_start_in) begin
         post_sync_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // setting selection; adds one register stage after the sync state

   toc_setting_sel u_sel (
      .sys_clk_in   (sys_clk_in),
      .rst_in       (rst_in),
      .config_in    (timing_offset_correction_config_r),
      .post_sync_in (post_sync_r),
      .setting_out  (setting_out)
   );

   // the limit also tells the preamble detector how much preamble to expect
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         symbol_rate_offset_limit_out <= toc_pkg::LIMIT_RESET;
      end else begin
         symbol_rate_offset_limit_out <=
            timing_offset_correction_config_r[toc_pkg::LIMIT_HI:toc_pkg::LIMIT_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word shows the setting in force and configuration hazards

   always_comb begin
      status_word                              = '0;
      status_word[toc_pkg::ST_POST_SYNC]       = setting_out.post_sync;
      status_word[toc_pkg::ST_PROP_MODE]       = setting_out.prop_mode;
      status_word[toc_pkg::ST_BLOCK_LO +: 3]   = setting_out.block_code;
      status_word[toc_pkg::ST_PROP_LO +: 4]    = setting_out.prop_num;
      status_word[toc_pkg::ST_INT_LO +: 4]     = setting_out.int_num;
      status_word[toc_pkg::ST_RESERVED]        = setting_out.cfg_reserved;
      // widest limit without carrier sense gating is a software slip
      status_word[toc_pkg::ST_GATE_MISS]       =
         (symbol_rate_offset_limit_out == toc_pkg::LIMIT_WIDE) &&
         !carrier_sense_gate_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read channel: one read at a time, data registered with the valid

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b0;
      end else begin
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out && !ar_take;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out  <= '0;
         s_axi_rresp_out  <= toc_pkg::RESP_OKAY;
      end else begin
         if (ar_take) begin
            s_axi_rvalid_out <= 1'b1;
            case (rd_addr)
               toc_pkg::ADDR_CONFIG: begin
                  s_axi_rdata_out <= {24'h00_0000, timing_offset_correction_config_r};
                  s_axi_rresp_out <= toc_pkg::RESP_OKAY;
               end
               toc_pkg::ADDR_STATUS: begin
                  s_axi_rdata_out <= status_word;
                  s_axi_rresp_out <= toc_pkg::RESP_OKAY;
               end
               default: begin
                  s_axi_rdata_out <= '0;
                  s_axi_rresp_out <= toc_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

endmodule

//--- toc_pkg.sv
package toc_pkg;

   // bus geometry
   localparam int unsigned AXI_ADDR_W = 8;
   localparam int unsigned AXI_DATA_W = 32;

   // register byte addresses
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // configuration register layout
   localparam int unsigned CFG_W       = 8;
   localparam int unsigned LIMIT_HI    = 7;
   localparam int unsigned LIMIT_LO    = 6;
   localparam int unsigned PRE_HI      = 5;
   localparam int unsigned PRE_LO      = 3;
   localparam int unsigned POST_HI     = 2;
   localparam int unsigned POST_LO     = 0;
   localparam logic [1:0] LIMIT_RESET = 2'h0;
   localparam logic [2:0] PRE_RESET   = 3'h1;
   localparam logic [2:0] POST_RESET  = 3'h3;

   // offset limit codes
   localparam logic [1:0] LIMIT_TIGHT    = 2'h0;   // below 0.2 percent
   localparam logic [1:0] LIMIT_MEDIUM   = 2'h1;   // below 2 percent
   localparam logic [1:0] LIMIT_RESERVED = 2'h2;
   localparam logic [1:0] LIMIT_WIDE     = 2'h3;   // below 12 percent

   // block length codes: window is 8 symbols shifted left by the code
   localparam logic [2:0] BLOCK_CODE_MAX = 3'h5;   // 256 symbols

   // scale numerators (proportional over 16, integral over 32)
   localparam logic [3:0] SCALE_NUM_0    = 4'h8;
   localparam logic [3:0] SCALE_NUM_1    = 4'h6;
   localparam logic [3:0] SCALE_NUM_2    = 4'h2;
   localparam logic [3:0] SCALE_NUM_3    = 4'h1;
   localparam logic [3:0] SCALE_NUM_SYNC = 4'h1;   // 1/16 after sync for code 1xx

   // status register layout
   localparam int unsigned ST_POST_SYNC  = 0;
   localparam int unsigned ST_PROP_MODE  = 1;
   localparam int unsigned ST_BLOCK_LO   = 2;
   localparam int unsigned ST_PROP_LO    = 8;
   localparam int unsigned ST_INT_LO     = 12;
   localparam int unsigned ST_RESERVED   = 16;
   localparam int unsigned ST_GATE_MISS  = 17;

   // applied timing recovery setting handed to the datapath
   typedef struct packed {
      logic       post_sync;      // sync word seen in this reception
      logic       prop_mode;      // symbol-by-symbol proportional loop active
      logic [2:0] block_code;     // block length code, window = 8 << code
      logic [3:0] prop_num;       // proportional scale numerator over 16
      logic [3:0] int_num;        // integral scale numerator over 32
      logic       cfg_reserved;   // a reserved code is in use by the current setting
   } toc_setting_t;

   // scale code to numerator, shared by proportional and integral paths
   function automatic logic [3:0] scale_num(input logic [1:0] code);
      logic [3:0] num;
      num = SCALE_NUM_0;
      case (code)
         2'h0:    num = SCALE_NUM_0;
         2'h1:    num = SCALE_NUM_1;
         2'h2:    num = SCALE_NUM_2;
         default: num = SCALE_NUM_3;
      endcase
      return num;
   endfunction

endpackage

//--- toc_setting_sel.sv
`timescale 1ns/1ps

// picks the setting in force from the register and the sync state
module toc_setting_sel (
   // clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   // configuration and state
   input  wire logic [7:0]            config_in,
   input  wire logic                  post_sync_in,
   // applied setting
   output toc_pkg::toc_setting_t      setting_out
);

   logic [1:0]            limit;
   logic [2:0]            pre_code;
   logic [2:0]            post_code;
   toc_pkg::toc_setting_t setting_nxt;

   assign limit     = config_in[toc_pkg::LIMIT_HI:toc_pkg::LIMIT_LO];
   assign pre_code  = config_in[toc_pkg::PRE_HI:toc_pkg::PRE_LO];
   assign post_code = config_in[toc_pkg::POST_HI:toc_pkg::POST_LO];

   ////////////////////////////////////////////////////////////////////////////
   // decode: block mode when the limit is zero, proportional loop otherwise
   always_comb begin
      setting_nxt              = '0;
      setting_nxt.post_sync    = post_sync_in;
      setting_nxt.prop_mode    = (limit != toc_pkg::LIMIT_TIGHT);
      setting_nxt.cfg_reserved = (limit == toc_pkg::LIMIT_RESERVED);
      if (limit == toc_pkg::LIMIT_TIGHT) begin
         // reserved lengths fall back to the longest window
         if (!post_sync_in) begin
            setting_nxt.block_code = (pre_code > toc_pkg::BLOCK_CODE_MAX) ?
                                     toc_pkg::BLOCK_CODE_MAX : pre_code;
            setting_nxt.cfg_reserved = (pre_code > toc_pkg::BLOCK_CODE_MAX);
         end else begin
            setting_nxt.block_code = (post_code > toc_pkg::BLOCK_CODE_MAX) ?
                                     toc_pkg::BLOCK_CODE_MAX : post_code;
            setting_nxt.cfg_reserved = (post_code > toc_pkg::BLOCK_CODE_MAX);
         end
      end else begin
         // pre-sync field names the proportional factor
         if (!pre_code[2]) begin
            setting_nxt.prop_num = toc_pkg::scale_num(pre_code[1:0]);
         end else if (post_sync_in) begin
            setting_nxt.prop_num = toc_pkg::SCALE_NUM_SYNC;
         end else begin
            setting_nxt.prop_num = toc_pkg::SCALE_NUM_0;  // fast pull-in before sync
         end
         // post-sync field names the integral factor; 1xx is undefined
         setting_nxt.int_num = toc_pkg::scale_num(post_code[2] ? 2'h3 : post_code[1:0]);
         if (post_code[2]) begin
            setting_nxt.cfg_reserved = 1'b1;
         end
      end
   end

   // registered so the datapath sees a glitch-free setting
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         setting_out <= '0;
      end else begin
         setting_out <= setting_nxt;
      end
   end

endmodule

//--- toc_config_regs_assertions.sv
`timescale 1ns/1ps

// bus handshakes and sync timing seen at the register block ports
module toc_config_regs_assertions #(
   parameter int unsigned ADDR_W = 8
) (
   // clock and reset
   input wire logic              sys_clk_in,
   input wire logic              rst_in,
   // axi4-lite
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic              s_axi_awvalid_in,
   input wire logic              s_axi_awready_out,
   input wire logic [31:0]       s_axi_wdata_in,
   input wire logic [3:0]        s_axi_wstrb_in,
   input wire logic              s_axi_wvalid_in,
   input wire logic              s_axi_wready_out,
   input wire logic [1:0]        s_axi_bresp_out,
   input wire logic              s_axi_bvalid_out,
   input wire logic              s_axi_bready_in,
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic              s_axi_arvalid_in,
   input wire logic              s_axi_arready_out,
   input wire logic [31:0]       s_axi_rdata_out,
   input wire logic [1:0]        s_axi_rresp_out,
   input wire logic              s_axi_rvalid_out,
   input wire logic              s_axi_rready_in,
   // demodulator side
   input wire logic              sync_event_in,
   input wire logic              rx_start_in,
   input wire logic              carrier_sense_gate_in,
   input toc_pkg::toc_setting_t  setting_out,
   input wire logic [1:0]        symbol_rate_offset_limit_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   ////////////////////////////////////////////////////////////////////////////
   // transfer steps
   sequence s_wr_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   // bus answers come on time and stand until accepted
   a_write_gets_resp: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_out)
      else $error("write response missing");
   a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
   a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_out)
      else $error("read data late");
   a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");

   // sync state: set two edges after the event, cleared by a new reception
   a_sync_sets_post: assert property (sync_event_in |-> ##2 setting_out.post_sync)
      else $error("sync not applied");
   a_rx_start_clears: assert property (rx_start_in && !sync_event_in
      |-> ##2 !setting_out.post_sync) else $error("post sync not cleared");

   // mode follows the limit field; unused fields stay zero
   a_prop_follows_limit: assert property (
      setting_out.prop_mode == (symbol_rate_offset_limit_out != 2'h0))
      else $error("mode does not match limit");
   a_block_fields: assert property (!setting_out.prop_mode |-> setting_out.block_code <= 3'h5
      && setting_out.prop_num == 4'h0 && setting_out.int_num == 4'h0)
      else $error("block mode fields wrong");
   a_prop_no_block: assert property (setting_out.prop_mode |-> setting_out.block_code == 3'h0)
      else $error("block code in proportional mode");
   a_limit_reserved: assert property (symbol_rate_offset_limit_out == 2'h2
      |-> setting_out.cfg_reserved) else $error("reserved limit not flagged");
endmodule

bind toc_config_regs toc_config_regs_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .sys_clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
   .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
   .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
   .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
   .s_axi_rvalid_out, .s_axi_rready_in, .sync_event_in, .rx_start_in,
   .carrier_sense_gate_in, .setting_out, .symbol_rate_offset_limit_out
);

//--- tb_timing_offset_correction_cfg.sv
`timescale 1ns/1ps

module tb_timing_offset_correction_cfg;
   logic                  sys_clk_in, rst_in, sync_event_in, rx_start_in, carrier_sense_gate_in;
   logic [7:0]            s_axi_awaddr_in, s_axi_araddr_in;
   logic [31:0]           s_axi_wdata_in, s_axi_rdata_out, rd;
   logic [3:0]            s_axi_wstrb_in, c;
   logic [2:0]            l;
   logic [1:0]            s_axi_bresp_out, s_axi_rresp_out, symbol_rate_offset_limit_out, resp;
   logic                  s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
   logic                  s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
   logic                  s_axi_rvalid_out, s_axi_rready_in;
   toc_pkg::toc_setting_t setting_out;
   int                    n_mismatch, n_checks;

   toc_config_regs #(.ADDR_W(8)) uut (
      .sys_clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
      .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
      .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
      .s_axi_rvalid_out, .s_axi_rready_in, .sync_event_in, .rx_start_in,
      .carrier_sense_gate_in, .setting_out, .symbol_rate_offset_limit_out);

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard; the run needs about five hundred cycles
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic conclude();
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   // upper data bits are set to show they are ignored
   // waits as long as the answer takes; only the watchdog ends a hang
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge sys_clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'hff_ffff, d};
      s_axi_wstrb_in <= s;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (s_axi_bvalid_out !== 1'b1);
      resp = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge sys_clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (s_axi_rvalid_out !== 1'b1);
      rd = s_axi_rdata_out;
      resp = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask
   // one-cycle sync and reception-start strobes, then let the setting settle
   task automatic pulse(input logic s, input logic x);
      @(posedge sys_clk_in);
      sync_event_in <= s;
      rx_start_in <= x;
      @(posedge sys_clk_in);
      sync_event_in <= 1'b0;
      rx_start_in <= 1'b0;
      tick(3);
   endtask
   function automatic logic [3:0] fac(input logic [2:0] k, input logic [3:0] alt);
      logic [3:0] t[4] = '{4'h8, 4'h6, 4'h2, 4'h1};
      return k[2] ? alt : t[k[1:0]];
   endfunction
   function automatic logic [2:0] blk(input logic [2:0] k);
      return (k > 3'h5) ? 3'h5 : k;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {sync_event_in, rx_start_in, carrier_sense_gate_in, s_axi_awvalid_in} = '0;
      {s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
      rst_in = 1'b1;
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      tick(2);
      check("setting at reset", setting_out, 32'h0000_0200);
      rd_reg(toc_pkg::ADDR_CONFIG);
      check("config at reset", rd, 32'h0000_000B);
      // refused or strobe-off accesses leave the register alone
      wr(toc_pkg::ADDR_STATUS, 8'h00, 4'hf);
      check("status write resp", resp, toc_pkg::RESP_SLVERR);
      wr(toc_pkg::ADDR_CONFIG, 8'hc0, 4'h0);
      check("strobe off resp", resp, toc_pkg::RESP_OKAY);
      rd_reg(8'h08);
      check("unmapped read resp", resp, toc_pkg::RESP_SLVERR);
      check("unmapped read data", rd, 32'h0000_0000);
      rd_reg(toc_pkg::ADDR_CONFIG);
      check("config unchanged", rd, 32'h0000_000B);
      // block mode: every pre and post code, switch at sync
      for (c = 0; c < 8; c++) begin
         wr(toc_pkg::ADDR_CONFIG, {2'h0, c[2:0], ~c[2:0]}, 4'h1);
         pulse(1'b0, 1'b1);
         check("pre block code", setting_out.block_code, blk(c[2:0]));
         check("pre reserved flag", setting_out.cfg_reserved, c > 5);
         pulse(1'b1, 1'b0);
         check("post sync", setting_out.post_sync, 1'b1);
         check("post block code", setting_out.block_code, blk(~c[2:0]));
         check("post reserved flag", setting_out.cfg_reserved, c < 2);
      end
      // sync wins over a reception start, a later start reverts
      pulse(1'b1, 1'b1);
      check("sync beats start", setting_out.post_sync, 1'b1);
      pulse(1'b0, 1'b1);
      check("start reverts", setting_out.post_sync, 1'b0);
      // proportional mode for every nonzero limit and scale code
      for (l = 1; l < 4; l++) begin
         for (c = 0; c < 8; c++) begin
            wr(toc_pkg::ADDR_CONFIG, {l[1:0], c[2:0], c[2:0]}, 4'h1);
            pulse(1'b0, 1'b1);
            check("limit out", symbol_rate_offset_limit_out, l[1:0]);
            check("prop mode", setting_out.prop_mode, 1'b1);
            check("pre prop factor", setting_out.prop_num, fac(c[2:0], 4'h8));
            pulse(1'b1, 1'b0);
            check("post prop factor", setting_out.prop_num, fac(c[2:0], 4'h1));
            check("integral factor", setting_out.int_num, fac(c[2:0], 4'h1));
            check("prop reserved", setting_out.cfg_reserved, l == 2 || c > 3);
         end
      end
      // widest limit without the carrier sense gate is flagged
      wr(toc_pkg::ADDR_CONFIG, 8'hcb, 4'h1);
      rd_reg(toc_pkg::ADDR_STATUS);
      check("gate missing", rd[17], 1'b1);
      check("status word", rd, 32'h0002_1603);
      @(posedge sys_clk_in);
      carrier_sense_gate_in <= 1'b1;
      rd_reg(toc_pkg::ADDR_STATUS);
      check("gate present", rd[17], 1'b0);
      check("status gated", rd, 32'h0000_1603);
      conclude();
   end
endmodule
